// File: hdl/mfx_core.sv
// Execution slice: diff-or-zero, external control, fence, extsw, xnor
//
// Operation
// - diff_or_zero_imm writes not(base_reg) plus sign-extended imm plus one.
// - If base_reg signed-greater than immediate, diff_or_zero_imm gives 0.
// - diff_or_zero_imm leaves cond_field0 and fx_exc_reg untouched.
// - eff_addr is index_reg when base field is 0, else base plus index.
// - xcc_on_flag set: ext load sends uncached request; word to dest_reg.
// - xcc_on_flag set: ext store sends address and store data to unit.
// - External load counts as load, external store as store, for protection.
// - Barrier completes earlier cache-inhibited loads and stores before any later access.
// - Barrier ordering covers cache-inhibited accesses only.
// - Barrier leaves cond_field0 and fx_exc_reg untouched.
// - sign_extend_word copies low 32 bits, fills upper half with bit 31.
// - Record sign_extend_word updates cond_field0; cy_flag also affected.
// - sign_extend_word only on 64-bit builds, else illegal instruction.
// - xnor_op writes complement of source XOR index_reg.
// - xnor_op never touches fx_exc_reg; record form updates cond_field0.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module mfx_core import mfx_pkg::*; #(
  parameter bit IS64  = 1'b1,
  parameter int GPR_N = 32
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  // AXI4-Lite write response
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  // External controller
  output logic                   XC_REQ,
  output mfx_xreq_s              XC_CMD,
  input  wire logic              XC_ACK,
  input  wire logic [31:0]       XC_RDATA,
  // Storage ordering and illegal-instruction exception
  input  wire logic              CI_PENDING,
  output logic                   IO_FENCE,
  output logic                   ILL_EXC
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mfx_state_e        st_q;
  mfx_instr_s        ins;
  logic [63:0]       gpr_q [GPR_N];
  logic [31:0]       xcfg_q, xer_q;
  logic [3:0]        cr0_q;
  logic [4:0]        gsel_q;
  logic              ill_q, xoff_q, ill_exc_q, fence_q;
  logic              xreq_q;
  mfx_xreq_s         xcmd_q;
  logic              awready_q, wready_q, bvalid_q;
  logic              arready_q, rvalid_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q, wdata_q, instr_q;
  logic [3:0]        wstrb_q;
  logic [ADDR_W-1:0] waddr_q;
  logic              aw_got_q, w_got_q;
  logic              aw_got_d, w_got_d, rvalid_d;
  logic              do_wr, go;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(logic [31:0] old,
                                        logic [31:0] nw,
                                        logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] cr0_calc(logic [63:0] v, logic so);
    logic lt, eq;
    lt = IS64 ? v[63] : v[31];
    eq = IS64 ? (v == 64'h0) : (v[31:0] == 32'h0);
    return {lt, ~lt & ~eq, eq, so};
  endfunction

  // ----------------------------------------------------------------
  // Decode and datapath
  // ----------------------------------------------------------------
  logic [63:0] ra_v, rb_v, rs_v, si_x, diff, xnor_v, exts_v, ea;
  logic        op_dozi, op_x, op_ld, op_st, op_fence, op_xnor;
  logic        op_exts, exts_ok, legal, xcc_on, dozi_gt, xc_op;

  assign ra_v     = gpr_q[ins.ra];
  assign rb_v     = gpr_q[ins.rb];
  assign rs_v     = gpr_q[ins.rt];
  assign si_x     = {{48{ins.rb[4]}}, ins.rb, ins.xo, ins.rc};
  assign diff     = ~ra_v + si_x + 64'h1;
  assign dozi_gt  = $signed(ra_v) > $signed(si_x);
  // zero base field means no base
  assign ea       = (ins.ra == 5'h00) ? rb_v : ra_v + rb_v;
  assign xnor_v   = ~(rs_v ^ rb_v);
  assign exts_v   = {{32{rs_v[31]}}, rs_v[31:0]};
  assign op_dozi  = ins.opc == OPC_DOZI;
  assign op_x     = ins.opc == OPC_X;
  assign op_ld    = op_x && ins.xo == XO_XLOAD;
  assign op_st    = op_x && ins.xo == XO_XSTORE;
  assign op_fence = op_x && ins.xo == XO_FENCE;
  assign op_xnor  = op_x && ins.xo == XO_XNOR;
  assign op_exts  = op_x && ins.xo == XO_EXTSW;
  assign exts_ok  = op_exts && IS64 && ins.rb == 5'h00;
  assign legal    = op_dozi | op_ld | op_st | op_fence | op_xnor | exts_ok;
  assign xcc_on   = xcfg_q[XCFG_EN];
  assign xc_op    = op_ld | op_st;
  assign ins      = mfx_instr_s'(instr_q);

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Address and data taken in either order; response after both
  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    if (bvalid_q && BREADY) begin
      aw_got_d = 1'b0;
      w_got_d  = 1'b0;
    end else begin
      if (AWVALID && awready_q) aw_got_d = 1'b1;
      if (WVALID && wready_q) w_got_d = 1'b1;
    end
    rvalid_d = rvalid_q;
    if (ARVALID && arready_q) rvalid_d = 1'b1;
    else if (RREADY) rvalid_d = 1'b0;
  end

  assign do_wr = aw_got_q && w_got_q && !bvalid_q;
  assign go    = do_wr && waddr_q == REG_INSTR && st_q == MFX_IDLE;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      waddr_q   <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      awready_q <= !aw_got_d;
      wready_q  <= !w_got_d;
      if (AWVALID && awready_q) waddr_q <= AWADDR;
      if (WVALID && wready_q) begin
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OK;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (waddr_q[1:0] != 2'h0 || waddr_q > REG_CR) ?
                  RESP_ERR : RESP_OK;
    end else if (BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OK;
    end else begin
      rvalid_q  <= rvalid_d;
      arready_q <= !rvalid_d;
      if (ARVALID && arready_q) begin
        rresp_q <= RESP_OK;
        unique case (ARADDR)
          REG_INSTR: rdata_q <= instr_q;
          REG_STAT:  rdata_q <= {28'h0, fence_q, xoff_q, ill_q,
                                 st_q != MFX_IDLE};
          REG_XCFG:  rdata_q <= xcfg_q;
          REG_GSEL:  rdata_q <= {27'h0, gsel_q};
          REG_GLO:   rdata_q <= gpr_q[gsel_q][31:0];
          REG_GHI:   rdata_q <= gpr_q[gsel_q][63:32];
          REG_XER:   rdata_q <= xer_q;
          REG_CR:    rdata_q <= {28'h0, cr0_q};
          default: begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_ERR;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Instruction word is only accepted while idle
  always_ff @(posedge CLK) begin
    if (RESET) begin
      instr_q <= 32'h0000_0000;
      xcfg_q  <= XCFG_RST;
      gsel_q  <= 5'h00;
    end else if (do_wr) begin
      if (go) instr_q <= merge(instr_q, wdata_q, wstrb_q);
      if (waddr_q == REG_XCFG) xcfg_q <= merge(xcfg_q, wdata_q, wstrb_q);
      if (waddr_q == REG_GSEL && wstrb_q[0]) gsel_q <= wdata_q[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_q <= MFX_IDLE;
    end else begin
      unique case (st_q)
        MFX_IDLE:  if (go) st_q <= MFX_EXEC;
        MFX_EXEC: begin
          if (xc_op && xcc_on) st_q <= MFX_XWAIT;
          else if (op_fence) st_q <= MFX_FENCE;
          else st_q <= MFX_IDLE;
        end
        MFX_XWAIT: if (xreq_q && XC_ACK) st_q <= MFX_IDLE;
        MFX_FENCE: if (!CI_PENDING) st_q <= MFX_IDLE;
      endcase
    end
  end

  // only cache-inhibited traffic is counted by CI_PENDING
  always_ff @(posedge CLK) begin
    if (RESET) fence_q <= 1'b0;
    else fence_q <= (st_q == MFX_EXEC && op_fence) ||
                    (st_q == MFX_FENCE && CI_PENDING);
  end

  // ----------------------------------------------------------------
  // External controller request
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      xreq_q <= 1'b0;
      xcmd_q <= '0;
    end else if (st_q == MFX_EXEC && xc_op && xcc_on) begin
      xreq_q       <= 1'b1;
      // store flag marks the protection class
      xcmd_q.we    <= op_st;
      xcmd_q.unit  <= xcfg_q[RID_W-1:0];
      // low address bits passed as given
      xcmd_q.addr  <= ea;
      // store data rides with the request
      xcmd_q.wdata <= rs_v[31:0];
    end else if (XC_ACK) begin
      xreq_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // General-purpose registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      for (int i = 0; i < GPR_N; i++) gpr_q[i] <= 64'h0;
    end else if (st_q == MFX_EXEC && op_dozi) begin
      // clamp to zero when base is larger
      gpr_q[ins.rt] <= dozi_gt ? 64'h0 : diff;
    end else if (st_q == MFX_EXEC && exts_ok) begin
      gpr_q[ins.ra] <= exts_v;
    end else if (st_q == MFX_EXEC && op_xnor) begin
      gpr_q[ins.ra] <= xnor_v;
    end else if (st_q == MFX_XWAIT && xreq_q && XC_ACK && op_ld) begin
      gpr_q[ins.rt] <= {32'h0, XC_RDATA};
    end else if (do_wr && waddr_q == REG_GLO) begin
      gpr_q[gsel_q][31:0] <= merge(gpr_q[gsel_q][31:0], wdata_q,
                                   wstrb_q);
    end else if (do_wr && waddr_q == REG_GHI) begin
      gpr_q[gsel_q][63:32] <= merge(gpr_q[gsel_q][63:32], wdata_q,
                                    wstrb_q);
    end
  end

  // ----------------------------------------------------------------
  // Condition field and exception register
  // ----------------------------------------------------------------
  // diff_or_zero_imm and barrier fall through untouched
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cr0_q <= 4'h0;
      xer_q <= 32'h0000_0000;
    end else if (st_q == MFX_EXEC && exts_ok && ins.rc) begin
      // cy_flag cleared as the listed side effect
      cr0_q         <= cr0_calc(exts_v, xer_q[XER_SO]);
      xer_q[XER_CA] <= 1'b0;
    end else if (st_q == MFX_EXEC && op_xnor && ins.rc) begin
      cr0_q <= cr0_calc(xnor_v, xer_q[XER_SO]);
    end else if (do_wr && waddr_q == REG_XER) begin
      xer_q <= merge(xer_q, wdata_q, wstrb_q);
    end else if (do_wr && waddr_q == REG_CR && wstrb_q[0]) begin
      cr0_q <= wdata_q[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Status and exception
  // ----------------------------------------------------------------
  // Sticky bits, write one to clear; a new event beats the clear
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ill_q     <= 1'b0;
      xoff_q    <= 1'b0;
      ill_exc_q <= 1'b0;
    end else begin
      ill_exc_q <= st_q == MFX_EXEC && !legal;
      if (st_q == MFX_EXEC && !legal) ill_q <= 1'b1;
      else if (do_wr && waddr_q == REG_STAT && wdata_q[ST_ILL])
        ill_q <= 1'b0;
      if (st_q == MFX_EXEC && xc_op && !xcc_on) xoff_q <= 1'b1;
      else if (do_wr && waddr_q == REG_STAT && wdata_q[ST_XOFF])
        xoff_q <= 1'b0;
    end
  end

  assign AWREADY  = awready_q;
  assign WREADY   = wready_q;
  assign BVALID   = bvalid_q;
  assign BRESP    = bresp_q;
  assign ARREADY  = arready_q;
  assign RVALID   = rvalid_q;
  assign RDATA    = rdata_q;
  assign RRESP    = rresp_q;
  assign XC_REQ   = xreq_q;
  assign XC_CMD   = xcmd_q;
  assign IO_FENCE = fence_q;
  assign ILL_EXC  = ill_exc_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_exec(logic c);
    st_q == MFX_EXEC && c;
  endsequence

  property p_dozi_diff;
    s_exec(op_dozi && !dozi_gt) |=> gpr_q[ins.rt] == $past(diff);
  endproperty
  a_dozi_diff: assert property (p_dozi_diff)
    else $error("diff result wrong");

  property p_dozi_zero;
    s_exec(op_dozi && dozi_gt) |=> gpr_q[ins.rt] == 64'h0;
  endproperty
  a_dozi_zero: assert property (p_dozi_zero)
    else $error("diff not clamped");

  property p_dozi_flags;
    s_exec(op_dozi || op_fence) |=> $stable(cr0_q) && $stable(xer_q);
  endproperty
  a_dozi_flags: assert property (p_dozi_flags)
    else $error("flags changed");

  property p_ea;
    s_exec(xc_op && xcc_on) |=> XC_REQ ##0
      XC_CMD.addr == $past(ins.ra == 5'h00 ? rb_v : ra_v + rb_v);
  endproperty
  a_ea: assert property (p_ea)
    else $error("address wrong");

  property p_xreq;
    s_exec(xc_op && xcc_on) |=> XC_REQ && XC_CMD.we == op_st &&
      XC_CMD.unit == xcfg_q[RID_W-1:0] ##1 (XC_REQ || $past(XC_ACK));
  endproperty
  a_xreq: assert property (p_xreq)
    else $error("request not raised");

  property p_xstore;
    s_exec(op_st && xcc_on) |=> XC_CMD.wdata == $past(rs_v[31:0]);
  endproperty
  a_xstore: assert property (p_xstore)
    else $error("store data wrong");

  sequence s_fence_wait;
    st_q == MFX_FENCE && CI_PENDING;
  endsequence

  property p_fence;
    s_fence_wait |=> st_q == MFX_FENCE && IO_FENCE && !XC_REQ;
  endproperty
  a_fence: assert property (p_fence)
    else $error("fence released early");

  property p_exts;
    s_exec(exts_ok) |=> gpr_q[ins.ra] ==
      {{32{$past(rs_v[31])}}, $past(rs_v[31:0])};
  endproperty
  a_exts: assert property (p_exts)
    else $error("sign extend wrong");

  property p_ill;
    s_exec(op_exts && !exts_ok) |=> ILL_EXC && ill_q;
  endproperty
  a_ill: assert property (p_ill)
    else $error("no illegal exception");

  property p_xnor;
    s_exec(op_xnor) |=> gpr_q[ins.ra] == $past(xnor_v) &&
      $stable(xer_q);
  endproperty
  a_xnor: assert property (p_xnor)
    else $error("xnor result wrong");

  property p_cr0;
    s_exec((op_xnor || exts_ok) && ins.rc) |=> $onehot(cr0_q[3:1]) &&
      cr0_q[CR_SO] == xer_q[XER_SO];
  endproperty
  a_cr0: assert property (p_cr0)
    else $error("cond field wrong");

endmodule

// File: hdl/mfx_pkg.sv
// Constants and types for the misc fixed-point execution slice
package mfx_pkg;

  // ----------------------------------------------------------------
  // Instruction encodings
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_DOZI  = 6'h09;
  localparam logic [5:0] OPC_X     = 6'h1F;
  localparam logic [9:0] XO_XLOAD  = 10'h136;
  localparam logic [9:0] XO_XSTORE = 10'h1B6;
  localparam logic [9:0] XO_FENCE  = 10'h356;
  localparam logic [9:0] XO_EXTSW  = 10'h3DA;
  localparam logic [9:0] XO_XNOR   = 10'h11C;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int         ADDR_W    = 8;
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_STAT  = 8'h04;
  localparam logic [7:0] REG_XCFG  = 8'h08;
  localparam logic [7:0] REG_GSEL  = 8'h0C;
  localparam logic [7:0] REG_GLO   = 8'h10;
  localparam logic [7:0] REG_GHI   = 8'h14;
  localparam logic [7:0] REG_XER   = 8'h18;
  localparam logic [7:0] REG_CR    = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          XCFG_EN  = 31;
  localparam int          RID_W    = 4;
  localparam int          XER_SO   = 31;
  localparam int          XER_CA   = 29;
  localparam int          CR_LT    = 3;
  localparam int          CR_GT    = 2;
  localparam int          CR_EQ    = 1;
  localparam int          CR_SO    = 0;
  localparam int          ST_BUSY  = 0;
  localparam int          ST_ILL   = 1;
  localparam int          ST_XOFF  = 2;
  localparam int          ST_FENCE = 3;
  localparam logic [31:0] XCFG_RST = 32'h0000_0000;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MFX_IDLE,
    MFX_EXEC,
    MFX_XWAIT,
    MFX_FENCE
  } mfx_state_e;

  typedef struct packed {
    logic [5:0] opc;
    logic [4:0] rt;
    logic [4:0] ra;
    logic [4:0] rb;
    logic [9:0] xo;
    logic       rc;
  } mfx_instr_s;

  typedef struct packed {
    logic             we;
    logic [RID_W-1:0] unit;
    logic [63:0]      addr;
    logic [31:0]      wdata;
  } mfx_xreq_s;

endpackage

// File: tb/mfx_core_tb.sv
// Self-checking bench of the misc fixed-point slice
`timescale 1ns/1ps
module mfx_core_tb import mfx_pkg::*;;
  // ----------------------------------------------------------------
  // Signals and reference state
  // ----------------------------------------------------------------
  logic        clk, rst, awv, wv, bry, arv, rry, ci, awr, wr, bv;
  logic        arr, rv, xreq, xack, fence, ill;
  logic [7:0]  awa, ara, lat;
  logic [1:0]  br, rr, lastb, r;
  logic [31:0] wd, rd, xrd, rdv, fx_exc_reg, s, u, seed;
  logic [3:0]  cr;
  logic [63:0] g [32];
  logic [63:0] a, b, e;
  mfx_xreq_s   xcmd, seen;
  int          fail_count, n_checks, ill_n, n_seen, n;

  mfx_core mfx_core_i (.CLK(clk), .RESET(rst), .AWADDR(awa),
    .AWVALID(awv), .AWREADY(awr), .WDATA(wd), .WSTRB(4'hF), .WVALID(wv),
    .WREADY(wr), .BRESP(br), .BVALID(bv), .BREADY(bry), .ARADDR(ara),
    .ARVALID(arv), .ARREADY(arr), .RDATA(rd), .RRESP(rr), .RVALID(rv),
    .RREADY(rry), .XC_REQ(xreq), .XC_CMD(xcmd), .XC_ACK(xack),
    .XC_RDATA(xrd), .CI_PENDING(ci), .IO_FENCE(fence), .ILL_EXC(ill));
  mfx_xc_model mfx_xc_model_i (.clk(clk), .rst(rst), .req(xreq),
    .cmd(xcmd), .ack(xack), .rdata(xrd), .lat(lat), .load_word(rdv),
    .seen(seen), .n_seen(n_seen));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (ill === 1'b1) ill_n++;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] ins(logic [4:0] p, q, c,
                                      logic [9:0] x, logic rc);
    return {OPC_X, p, q, c, x, rc};
  endfunction
  function automatic logic [3:0] flg(logic [63:0] v);
    return {$signed(v) < 0, $signed(v) > 0, v == 0, fx_exc_reg[XER_SO]};
  endfunction
  task automatic chk(string nm, logic [63:0] ex, logic [63:0] v);
    n_checks++;
    if (v !== ex) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, v);
    end
  endtask
  task automatic axw(logic [7:0] ad, logic [31:0] d);
    @(posedge clk);
    awa <= ad;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    lastb = br;
    bry <= 1'b0;
  endtask
  task automatic axr(logic [7:0] ad, output logic [31:0] d,
                     output logic [1:0] q);
    @(posedge clk);
    ara <= ad;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rd;
    q = rr;
    rry <= 1'b0;
  endtask
  task automatic setg(int i, logic [63:0] v);
    g[i] = v;
    axw(REG_GSEL, 32'(i));
    axw(REG_GLO, v[31:0]);
    axw(REG_GHI, v[63:32]);
  endtask
  task automatic idle();
    do axr(REG_STAT, s, r); while (s[ST_BUSY] !== 1'b0);
  endtask
  task automatic exec(logic [31:0] w);
    axw(REG_INSTR, w);
    idle();
  endtask
  // Result register, flags and exception word against the model
  task automatic verify(int i);
    logic [63:0] v;
    axw(REG_GSEL, 32'(i));
    axr(REG_GLO, v[31:0], r);
    axr(REG_GHI, v[63:32], r);
    chk("gpr", g[i], v);
    axr(REG_CR, v[31:0], r);
    chk("cr", cr, v[3:0]);
    axr(REG_XER, v[31:0], r);
    chk("xer", fx_exc_reg, v[31:0] & 32'hE000_0000);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
  initial begin
    {awv, wv, bry, arv, rry, ci} = '0;
    {awa, ara, lat, wd, rdv, fx_exc_reg, cr} = '0;
    {fail_count, n_checks, ill_n} = '0;
    seed = 32'h0000_CBC2;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    axr(REG_XCFG, s, r);
    chk("xcfg", XCFG_RST, s);
    for (int k = 0; k < 12; k++) begin
      b = {rnd(), rnd()};
      a = (k < 3) ? 64'($signed(b[15:0]) + k - 1) : {rnd(), rnd()};
      fx_exc_reg = rnd() & 32'hE000_0000;
      axw(REG_XER, fx_exc_reg);
      setg(1, a);
      setg(2, b);
      e = {{48{b[15]}}, b[15:0]};
      g[3] = ($signed(a) > $signed(e)) ? '0 : ~a + e + 1;
      exec({OPC_DOZI, 5'h03, 5'h01, b[15:0]});
      verify(3);
      g[4] = ~(a ^ b);
      if (k[0]) cr = flg(g[4]);
      exec(ins(5'h01, 5'h04, 5'h02, XO_XNOR, k[0]));
      verify(4);
      g[5] = {{32{a[31]}}, a[31:0]};
      cr = flg(g[5]);
      fx_exc_reg[XER_CA] = 1'b0;
      exec(ins(5'h01, 5'h05, 5'h00, XO_EXTSW, 1'b1));
      verify(5);
    end
    n = ill_n;
    exec(ins(5'h01, 5'h05, 5'h03, XO_EXTSW, 1'b0));
    verify(5);
    chk("ill", 64'(n + 1), 64'(ill_n));
    $display("test alu done");
    for (int k = 0; k < 4; k++) begin
      u = rnd();
      axw(REG_XCFG, {1'b1, 27'h0, u[3:0]});
      setg(0, {rnd(), rnd() & 32'hFFFF_FFFC});
      setg(1, {rnd(), rnd() & 32'hFFFF_FFFC});
      setg(2, {rnd(), rnd() & 32'hFFFF_FFFC});
      lat = 8'(k * 3);
      rdv = rnd();
      e = k[0] ? g[1] + g[2] : g[2];
      n = n_seen;
      g[6] = {32'h0, rdv};
      exec(ins(5'h06, {4'h0, k[0]}, 5'h02, XO_XLOAD, 1'b0));
      chk("xaddr", e, seen.addr);
      chk("xld", {1'b0, u[3:0]}, {seen.we, seen.unit});
      verify(6);
      exec(ins(5'h06, {4'h0, k[0]}, 5'h02, XO_XSTORE, 1'b0));
      chk("xaddr", e, seen.addr);
      chk("xst", {1'b1, u[3:0]}, {seen.we, seen.unit});
      chk("xsd", rdv, seen.wdata);
      chk("xcnt", 64'(n + 2), 64'(n_seen));
    end
    axw(REG_XCFG, 32'h0000_0003);
    n = n_seen;
    exec(ins(5'h07, 5'h00, 5'h02, XO_XLOAD, 1'b0));
    axr(REG_STAT, s, r);
    chk("xoff", {n, 1'b1}, {n_seen, s[ST_XOFF]});
    $display("test external done");
    ci <= 1'b1;
    axw(REG_INSTR, ins(5'h00, 5'h00, 5'h00, XO_FENCE, 1'b0));
    repeat (6) @(posedge clk);
    axr(REG_STAT, s, r);
    chk("fence", 3'b111, {fence, s[ST_FENCE], s[ST_BUSY]});
    ci <= 1'b0;
    idle();
    chk("fence", 1'b0, fence);
    verify(6);
    $display("test barrier done");
    axr(8'h20, s, r);
    chk("rerr", {RESP_ERR, 32'h0}, {r, s});
    axw(8'h06, 32'h0);
    chk("werr", RESP_ERR, lastb);
    $display("test bus done");
    close_out();
  end
endmodule

// File: tb/mfx_xc_model.sv
// Behavioural model of the external controller
`timescale 1ns/1ps
module mfx_xc_model import mfx_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Request side
  input  wire logic        req,
  input  wire mfx_xreq_s   cmd,
  output logic             ack,
  output logic [31:0]      rdata,
  // Bench control and record
  input  wire logic [7:0]  lat,
  input  wire logic [31:0] load_word,
  output mfx_xreq_s        seen,
  output int               n_seen
);
  int cnt;

  // answer after lat
  // Data line toggles when idle so stale words never look valid
  always @(posedge clk) begin
    ack <= 1'b0;
    rdata <= ~rdata;
    if (rst) begin
      cnt <= 0;
      n_seen <= 0;
      rdata <= 32'h0000_0000;
    end else if (req && !ack) begin
      if (cnt >= lat) begin
        ack <= 1'b1;
        rdata <= load_word;
        seen <= cmd;
        n_seen <= n_seen + 1;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
